// File: src/sfl_top.sv
`timescale 1ns/1ps
`include "sfl_defs.svh"
module sfl_top #(
  parameter int AW               = `SFL_ADDR_W,
  parameter int SECTOR_ERASE_CYC = `SFL_SECTOR_ERASE_CYC,
  parameter int BLOCK_ERASE_CYC  = `SFL_BLOCK_ERASE_CYC
) (
  // System
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // Serial link
  input  wire logic          csN,
  input  wire logic          sclk,
  input  wire logic          si,
  output logic               soOut,
  output logic               soOe,
  // Protection
  input  wire logic          protOn,
  input  wire logic [AW-1:0] protLow,
  // Status
  output logic               busy,
  output logic               writeEnableLatch,
  output logic               aaiActive,
  output logic               busyPinMode
);
  localparam logic [31:0] PROG_CYC = 32'(`SFL_PROG_CYC);

  logic             rstMeta, rstSyncN;
  logic             csMeta, csSync, csLast;
  logic             sclkMeta, sclkSync, sclkLast;
  logic             siMeta, siSync;
  logic             csLow, csRise, sclkRise, sclkFall, byteDone;
  logic [7:0]       shiftIn, newByte, opReg, outShift, memRdata, statusByte, src;
  logic [5:0]       bitCnt;
  logic [2:0]       outBit;
  logic [23:0]      addrIn;
  logic [15:0]      dataReg, wrBuf, startBuf;
  logic [AW-1:0]    ptr, wrAddr, memAddr, addrA, evenA, aaiPtr, startAddr;
  logic [AW-1:0]    eraseStart, eraseEnd;
  logic [AW:0]      wrLeft, startLen, eraseLen;
  logic [31:0]      startTime, eraseTime;
  logic             welReg, aaiReg, aaiStop, pinMode, busyReg;
  logic             startWr, timerBusy, busyNow, memWe;
  int               eraseLg;
  sfl_pkg::sfl_state_t state;

  function automatic logic isProt(input logic [AW-1:0] a);
    isProt = protOn && (a >= protLow);
  endfunction

  function automatic logic [AW-1:0] alignDown(input logic [AW-1:0] a, input int lg);
    alignDown = (a >> lg) << lg;
  endfunction

  // Reset release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta  <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta  <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      csMeta   <= 1'b1;
      csSync   <= 1'b1;
      csLast   <= 1'b1;
      sclkMeta <= 1'b0;
      sclkSync <= 1'b0;
      sclkLast <= 1'b0;
      siMeta   <= 1'b0;
      siSync   <= 1'b0;
    end else begin
      csMeta   <= csN;
      csSync   <= csMeta;
      csLast   <= csSync;
      sclkMeta <= sclk;
      sclkSync <= sclkMeta;
      sclkLast <= sclkSync;
      siMeta   <= si;
      siSync   <= siMeta;
    end
  end

  assign csLow    = ~csSync;
  assign csRise   = csSync & ~csLast;
  assign sclkRise = csLow & sclkSync & ~sclkLast;
  assign sclkFall = csLow & ~sclkSync & sclkLast;
  assign newByte  = {shiftIn[6:0], siSync};
  assign byteDone = (bitCnt[2:0] == 3'h7);
  assign addrA    = addrIn[AW-1:0];
  assign evenA    = {addrA[AW-1:1], 1'b0};

  // Bit capture
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      shiftIn <= 8'h00;
      bitCnt  <= 6'h00;
    end else if (!csLow) begin
      bitCnt <= 6'h00;
    end else if (sclkRise) begin
      shiftIn <= newByte;
      if (bitCnt != 6'h3f) begin
        bitCnt <= bitCnt + 6'h01;
      end
    end
  end

  // Command sequencer
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state   <= sfl_pkg::ST_OP;
      opReg   <= 8'h00;
      addrIn  <= 24'h000000;
      dataReg <= 16'h0000;
    end else if (!csLow) begin
      state <= sfl_pkg::ST_OP;
    end else if (sclkRise && byteDone) begin
      unique case (state)
        sfl_pkg::ST_OP: begin
          opReg <= newByte;
          if (aaiReg && !(newByte == `SFL_OP_AAI || newByte == `SFL_OP_WRITE_DISABLE_CMD ||
              (newByte == `SFL_OP_STATUS_READ_CMD && !pinMode))) begin
            state <= sfl_pkg::ST_HOLD;
          end else begin
            case (newByte)
              `SFL_OP_READ, `SFL_OP_FREAD, `SFL_OP_PROG,
              `SFL_OP_SEC, `SFL_OP_BLK32, `SFL_OP_BLK64: state <= sfl_pkg::ST_ADDR;
              `SFL_OP_AAI: state <= aaiReg ? sfl_pkg::ST_DATA : sfl_pkg::ST_ADDR;
              `SFL_OP_STATUS_READ_CMD: state <= sfl_pkg::ST_READ;
              default: state <= sfl_pkg::ST_HOLD;
            endcase
          end
        end
        sfl_pkg::ST_ADDR: begin
          addrIn <= {addrIn[15:0], newByte};
          if (bitCnt == `SFL_ADDR_LAST) begin
            if (opReg == `SFL_OP_READ) begin
              state <= sfl_pkg::ST_READ;
            end else if (opReg == `SFL_OP_FREAD) begin
              state <= sfl_pkg::ST_DUMMY;
            end else begin
              state <= sfl_pkg::ST_DATA;
            end
          end
        end
        sfl_pkg::ST_DUMMY: state <= sfl_pkg::ST_READ;
        sfl_pkg::ST_DATA: dataReg <= {dataReg[7:0], newByte};
        sfl_pkg::ST_READ, sfl_pkg::ST_HOLD: ;
      endcase
    end
  end

  // Serial output and read pointer
  assign statusByte = {1'b0, aaiReg, 4'h0, welReg, busyNow};
  assign src        = (opReg == `SFL_OP_STATUS_READ_CMD) ? statusByte : memRdata;

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ptr      <= '0;
      soOut    <= 1'b0;
      soOe     <= 1'b0;
      outShift <= 8'h00;
      outBit   <= 3'h0;
    end else if (!csLow) begin
      soOe   <= 1'b0;
      outBit <= 3'h0;
    end else begin
      if (sclkRise && byteDone && state == sfl_pkg::ST_ADDR &&
          bitCnt == `SFL_ADDR_LAST && opReg == `SFL_OP_READ) begin
        ptr <= AW'({addrIn[15:0], newByte});
      end
      if (sclkRise && byteDone && state == sfl_pkg::ST_DUMMY) begin
        ptr <= addrA;
      end
      if (state == sfl_pkg::ST_READ) begin
        if (sclkFall) begin
          soOe   <= 1'b1;
          outBit <= outBit + 3'h1;
          if (outBit == 3'h0) begin
            soOut    <= src[7];
            outShift <= {src[6:0], 1'b0};
            if (opReg != `SFL_OP_STATUS_READ_CMD) begin
              ptr <= ptr + AW'(1);
            end
          end else begin
            soOut    <= outShift[7];
            outShift <= {outShift[6:0], 1'b0};
          end
        end
      end else if (pinMode && aaiReg) begin
        soOe  <= 1'b1;
        soOut <= ~busyNow;
      end
    end
  end

  // Program and erase start on select rise
  always_comb begin
    unique case (opReg)
      `SFL_OP_SEC:   eraseLg = `SFL_SEC_LOG2;
      `SFL_OP_BLK32: eraseLg = `SFL_BLK32_LOG2;
      default:       eraseLg = `SFL_BLK64_LOG2;
    endcase
  end

  assign eraseStart = alignDown(addrA, eraseLg);
  assign eraseLen   = (AW+1)'(1) << ((eraseLg > AW) ? AW : eraseLg);
  assign eraseEnd   = eraseStart + eraseLen[AW-1:0] - AW'(1);
  assign eraseTime  = (opReg == `SFL_OP_SEC) ? 32'(SECTOR_ERASE_CYC) : 32'(BLOCK_ERASE_CYC);

  always_comb begin
    startWr   = 1'b0;
    startAddr = addrA;
    startLen  = '0;
    startBuf  = 16'hffff;
    startTime = PROG_CYC;
    if (csRise && welReg && !busyNow) begin
      case (opReg)
        `SFL_OP_PROG: begin
          if (bitCnt == `SFL_BITS_PROG && !aaiReg && !isProt(addrA)) begin
            startWr  = 1'b1;
            startLen = (AW+1)'(1);
            startBuf = {dataReg[7:0], 8'hff};
          end
        end
        `SFL_OP_AAI: begin
          if (!aaiReg && bitCnt == `SFL_BITS_AAI1 &&
              !isProt({addrA[AW-1:1], 1'b1})) begin
            startWr   = 1'b1;
            startAddr = evenA;
            startLen  = (AW+1)'(2);
            startBuf  = dataReg;
          end else if (aaiReg && bitCnt == `SFL_BITS_AAIN && !aaiStop &&
                       !isProt({aaiPtr[AW-1:1], 1'b1})) begin
            startWr   = 1'b1;
            startAddr = aaiPtr;
            startLen  = (AW+1)'(2);
            startBuf  = dataReg;
          end
        end
        `SFL_OP_SEC, `SFL_OP_BLK32, `SFL_OP_BLK64: begin
          if (bitCnt == `SFL_BITS_ERASE && !aaiReg && !isProt(eraseEnd)) begin
            startWr   = 1'b1;
            startAddr = eraseStart;
            startLen  = eraseLen;
            startTime = eraseTime;
          end
        end
        default: ;
      endcase
    end
  end

  // Write enable, word sequence and busy pin flags
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      welReg  <= 1'b0;
      aaiReg  <= 1'b0;
      aaiStop <= 1'b0;
      pinMode <= 1'b0;
      aaiPtr  <= '0;
    end else begin
      if (csRise && bitCnt == `SFL_BITS_CMD) begin
        case (opReg)
          `SFL_OP_WRITE_ENABLE_CMD: welReg <= 1'b1;
          `SFL_OP_WRITE_DISABLE_CMD: begin
            welReg  <= 1'b0;
            aaiReg  <= 1'b0;
            aaiStop <= 1'b0;
          end
          `SFL_OP_BUSY_OUTPUT_ENABLE_CMD: pinMode <= 1'b1;
          `SFL_OP_BUSY_OUTPUT_DISABLE_CMD: pinMode <= 1'b0;
          default: ;
        endcase
      end
      if (startWr) begin
        if (opReg == `SFL_OP_AAI) begin
          aaiReg  <= 1'b1;
          aaiPtr  <= startAddr + AW'(2);
          aaiStop <= &startAddr[AW-1:1];
        end else begin
          welReg <= 1'b0;
        end
      end
    end
  end

  // Array writer
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      wrAddr <= '0;
      wrLeft <= '0;
      wrBuf  <= 16'hffff;
    end else if (startWr) begin
      wrAddr <= startAddr;
      wrLeft <= startLen;
      wrBuf  <= startBuf;
    end else if (wrLeft != '0) begin
      wrAddr <= wrAddr + AW'(1);
      wrLeft <= wrLeft - (AW+1)'(1);
      wrBuf  <= {wrBuf[7:0], 8'hff};
    end
  end

  assign memWe   = (wrLeft != '0);
  assign memAddr = memWe ? wrAddr : ptr;
  assign busyNow = timerBusy | memWe;

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      busyReg <= 1'b0;
    end else begin
      busyReg <= busyNow;
    end
  end

  assign busy             = busyReg;
  assign writeEnableLatch = welReg;
  assign aaiActive        = aaiReg;
  assign busyPinMode      = pinMode;

  sfl_timer #(.W(32)) u_timer (
    .clk     (clk_sys),
    .rstN    (rstSyncN),
    .load    (startWr),
    .loadVal (startTime),
    .busy    (timerBusy)
  );

  sfl_mem #(.AW(AW)) u_mem (
    .clk   (clk_sys),
    .addr  (memAddr),
    .we    (memWe),
    .wdata (wrBuf[15:8]),
    .rdata (memRdata)
  );

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstSyncN);

  sequence sCmd(logic [7:0] op, logic [5:0] n);
    csRise && opReg == op && bitCnt == n;
  endsequence

  sequence sByteOut;
    sclkFall && state == sfl_pkg::ST_READ && outBit == 3'h0;
  endsequence

  chk_wel_set: assert property (sCmd(`SFL_OP_WRITE_ENABLE_CMD, 6'h08) |=> welReg)
    else $error("write enable did not set latch");
  chk_write_disable_cmd_clear: assert property (sCmd(`SFL_OP_WRITE_DISABLE_CMD, 6'h08) |=> !welReg && !aaiReg)
    else $error("write disable did not clear flags");
  chk_nowel_ignore: assert property (csRise && !welReg && !busyNow |=> !busyNow [*2])
    else $error("write started without latch");
  chk_read_wrap: assert property (sByteOut and (opReg != `SFL_OP_STATUS_READ_CMD && ptr == '1)
    |=> ptr == '0) else $error("read pointer did not wrap");
  chk_read_msb: assert property (sByteOut |=> soOe && soOut == $past(src[7]))
    else $error("read byte not driven msb first");
  chk_shift_msb: assert property (sclkRise |=> shiftIn[0] == $past(siSync))
    else $error("input bit not shifted in");
  chk_sector_len: assert property (startWr && opReg == `SFL_OP_SEC |=>
    wrLeft == (AW+1)'(4096) && wrAddr[11:0] == 12'h000) else $error("sector range wrong");
  chk_prot_skip: assert property (startWr |-> !isProt(startAddr + startLen[AW-1:0] - AW'(1)))
    else $error("protected area written");
  chk_aai_order: assert property (startWr && opReg == `SFL_OP_AAI |=>
    memWe && !memAddr[0] ##1 memWe && memAddr[0]) else $error("word byte order wrong");
  chk_aai_gate: assert property (sclkRise && byteDone && state == sfl_pkg::ST_OP && aaiReg
    && pinMode && newByte == `SFL_OP_STATUS_READ_CMD |=> state == sfl_pkg::ST_HOLD)
    else $error("status read accepted in pin mode");
  chk_pin_busy: assert property (csLow && pinMode && aaiReg && state != sfl_pkg::ST_READ
    |=> soOe && soOut == !$past(busyNow)) else $error("busy pin not driven");
  chk_cs_float: assert property (!csLow |=> !soOe)
    else $error("output not floated");
  chk_aai_nowrap: assert property (csRise && aaiStop && aaiReg |=> wrLeft == '0)
    else $error("word sequence wrapped");
endmodule

// File: shared/sfl_defs.svh
`ifndef SFL_DEFS_SVH
`define SFL_DEFS_SVH
`define SFL_ADDR_W 19
`define SFL_OP_READ 8'h03
`define SFL_OP_FREAD 8'h0b
`define SFL_OP_PROG 8'h02
`define SFL_OP_AAI 8'had
`define SFL_OP_STATUS_READ_CMD 8'h05
`define SFL_OP_WRITE_ENABLE_CMD 8'h06
`define SFL_OP_WRITE_DISABLE_CMD 8'h04
`define SFL_OP_BUSY_OUTPUT_ENABLE_CMD 8'h70
`define SFL_OP_BUSY_OUTPUT_DISABLE_CMD 8'h80
`define SFL_OP_SEC 8'h20
`define SFL_OP_BLK32 8'h52
`define SFL_OP_BLK64 8'hd8
`define SFL_SEC_LOG2 12
`define SFL_BLK32_LOG2 15
`define SFL_BLK64_LOG2 16
`define SFL_BITS_CMD 6'h08
`define SFL_BITS_ERASE 6'h20
`define SFL_BITS_PROG 6'h28
`define SFL_BITS_AAI1 6'h30
`define SFL_BITS_AAIN 6'h18
`define SFL_ADDR_LAST 6'h1f
`define SFL_CLK_NS 50
`define SFL_PROG_TIME_NS 10000
`define SFL_SECTOR_ERASE_TIME_MS 25
`define SFL_BLOCK_ERASE_TIME_MS 25
`define SFL_PROG_CYC ((`SFL_PROG_TIME_NS + `SFL_CLK_NS - 1) / `SFL_CLK_NS)
`define SFL_SECTOR_ERASE_CYC (`SFL_SECTOR_ERASE_TIME_MS * 1000000 / `SFL_CLK_NS)
`define SFL_BLOCK_ERASE_CYC (`SFL_BLOCK_ERASE_TIME_MS * 1000000 / `SFL_CLK_NS)
`endif

// File: shared/sfl_pkg.sv
package sfl_pkg;
  typedef enum logic [5:0] {
    ST_OP    = 6'h01,
    ST_ADDR  = 6'h02,
    ST_DUMMY = 6'h04,
    ST_DATA  = 6'h08,
    ST_READ  = 6'h10,
    ST_HOLD  = 6'h20
  } sfl_state_t;
endpackage

// File: src/sfl_mem.sv
`timescale 1ns/1ps
module sfl_mem #(
  parameter int AW = 19
) (
  // Clock
  input  wire logic          clk,
  // Access
  input  wire logic [AW-1:0] addr,
  input  wire logic          we,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      mem[i] = 8'hff;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// File: src/sfl_timer.sv
`timescale 1ns/1ps
module sfl_timer #(
  parameter int W = 32
) (
  // System
  input  wire logic         clk,
  input  wire logic         rstN,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  output logic              busy
);
  logic [W-1:0] count;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      count <= '0;
      busy  <= 1'b0;
    end else if (load) begin
      count <= loadVal;
      busy  <= (loadVal != '0);
    end else if (count != '0) begin
      count <= count - W'(1);
      busy  <= (count != W'(1));
    end
  end
endmodule

// File: tb/sfl_spi_host.sv
`timescale 1ns/1ps
module sfl_spi_host (
  // System
  input  wire logic clk,
  // Link
  output logic      csN,
  output logic      sclk,
  output logic      si,
  input  wire logic so
);
  // Half serial period in system clocks, 400 ns period
  localparam int Half = 4;

  initial begin
    csN  = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end

  task automatic ck(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Select held low for the whole frame
  task automatic select();
    ck(1);
    csN = 1'b0;
    ck(Half);
  endtask

  // Serial clock stands low between frames
  task automatic deselect();
    ck(Half);
    csN = 1'b1;
    si  = ~si;
    ck(8);
  endtask

  // Most significant bit first, held over the rising edge
  task automatic sendByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      si = b[i];
      ck(Half);
      sclk = 1'b1;
      ck(Half);
      sclk = 1'b0;
    end
  endtask

  task automatic sendAddr(input logic [23:0] a);
    sendByte(a[23:16]);
    sendByte(a[15:8]);
    sendByte(a[7:0]);
  endtask

  // Unused input toggles; output sampled late in the high phase
  task automatic readByte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      si = ~si;
      ck(Half);
      sclk = 1'b1;
      ck(Half);
      b[i] = so;
      sclk = 1'b0;
    end
  endtask
endmodule

// File: tb/tb_spi_flash_read_program_erase.sv
`timescale 1ns/1ps
module tb_spi_flash_read_program_erase;
  typedef struct packed {
    logic        write_enable_cmd;
    logic        pOn;
    logic [12:0] pLow;
    logic [23:0] a;
    logic [7:0]  d;
    logic        fast;
    logic [7:0]  e;
  } sfl_row_t;

  logic        clkSys;
  logic        rstN;
  logic        csN;
  logic        sclk;
  logic        si;
  logic        soOut;
  logic        soOe;
  logic        protOn;
  logic [12:0] protLow;
  logic        busy;
  logic        writeEnableLatch;
  logic        aaiActive;
  logic        busyPinMode;
  wire         soLine = soOe ? soOut : 1'bz;
  int          n_fail;
  int          checked;
  logic [7:0]  d;

  sfl_row_t rows[5] = '{
    '{1'b1, 1'b0, 13'h0000, 24'h000010, 8'ha5, 1'b0, 8'ha5},
    '{1'b1, 1'b0, 13'h0000, 24'h000011, 8'h5a, 1'b1, 8'h5a},
    '{1'b1, 1'b1, 13'h1800, 24'h001900, 8'h3c, 1'b0, 8'hff},
    '{1'b1, 1'b1, 13'h1800, 24'h0017ff, 8'hc3, 1'b1, 8'hc3},
    '{1'b0, 1'b0, 13'h0000, 24'h000020, 8'h96, 1'b0, 8'hff}
  };

  sfl_top #(
    .AW               (13),
    .SECTOR_ERASE_CYC (100),
    .BLOCK_ERASE_CYC  (100)
  ) u_dut (
    .clk_sys          (clkSys),
    .rst_n            (rstN),
    .csN              (csN),
    .sclk             (sclk),
    .si               (si),
    .soOut            (soOut),
    .soOe             (soOe),
    .protOn           (protOn),
    .protLow          (protLow),
    .busy             (busy),
    .writeEnableLatch (writeEnableLatch),
    .aaiActive        (aaiActive),
    .busyPinMode      (busyPinMode)
  );

  sfl_spi_host u_host (
    .clk  (clkSys),
    .csN  (csN),
    .sclk (sclk),
    .si   (si),
    .so   (soLine)
  );

  initial begin
    clkSys = 1'b0;
    forever #25 clkSys = ~clkSys;
  end

  task automatic conclude();
    if (n_fail == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Flags {busy, latch, word sequence, pin mode, output enable}
  task automatic flags(input logic [4:0] e);
    chk({3'h0, busy, writeEnableLatch, aaiActive, busyPinMode, soOe}, {3'h0, e});
  endtask

  task automatic waitIdle();
    for (int i = 0; i < 40000 && busy !== 1'b0; i++) u_host.ck(1);
    chk({7'h0, busy}, 8'h00);
  endtask

  task automatic cmd(input logic [7:0] op);
    u_host.select();
    u_host.sendByte(op);
    u_host.deselect();
  endtask

  task automatic frame(input logic [7:0] op, input logic [23:0] a, input logic [7:0] b);
    u_host.select();
    u_host.sendByte(op);
    u_host.sendAddr(a);
    u_host.sendByte(b);
    u_host.deselect();
  endtask

  task automatic word(input logic first, input logic [23:0] a, input logic [7:0] d0,
                      input logic [7:0] d1);
    u_host.select();
    u_host.sendByte(8'had);
    if (first) u_host.sendAddr(a);
    u_host.sendByte(d0);
    u_host.sendByte(d1);
    u_host.deselect();
  endtask

  task automatic readChk(input logic [7:0] op, input logic [23:0] a, input logic [7:0] ex[$]);
    logic [7:0] r;
    u_host.select();
    u_host.sendByte(op);
    u_host.sendAddr(a);
    if (op == 8'h0b) u_host.sendByte(8'h00);
    foreach (ex[i]) begin
      u_host.readByte(r);
      chk(r, ex[i]);
    end
    u_host.deselect();
  endtask

  task automatic erase(input logic [7:0] op, input logic [23:0] a);
    cmd(8'h06);
    u_host.select();
    u_host.sendByte(op);
    u_host.sendAddr(a);
    u_host.deselect();
    waitIdle();
  endtask

  initial begin
    #(60000 * 50);
    n_fail++;
    conclude();
  end

  initial begin
    rstN    = 1'b0;
    protOn  = 1'b0;
    protLow = 13'h0000;
    repeat (20) @(negedge clkSys);
    rstN = 1'b1;
    repeat (6) @(negedge clkSys);
    flags(5'h00);
    foreach (rows[i]) begin
      protOn  = rows[i].pOn;
      protLow = rows[i].pLow;
      if (rows[i].write_enable_cmd) cmd(8'h06);
      frame(8'h02, rows[i].a, rows[i].d);
      waitIdle();
      readChk(rows[i].fast ? 8'h0b : 8'h03, rows[i].a, '{rows[i].e});
      flags({1'b0, rows[i].write_enable_cmd && rows[i].e != rows[i].d, 3'h0});
    end
    protOn = 1'b0;
    // Latch set, then busy held for the program time
    cmd(8'h06);
    flags(5'b01000);
    frame(8'h02, 24'h000030, 8'h77);
    chk({7'h0, busy}, 8'h01);
    u_host.ck(150);
    chk({7'h0, busy}, 8'h01);
    u_host.ck(80);
    chk({7'h0, busy}, 8'h00);
    readChk(8'h03, 24'h000030, '{8'h77});
    // Word sequence from an odd address, status polling
    cmd(8'h06);
    word(1'b1, 24'h000101, 8'ha1, 8'hb2);
    waitIdle();
    flags(5'b01100);
    u_host.select();
    u_host.sendByte(8'h05);
    u_host.readByte(d);
    chk(d, 8'h42);
    u_host.deselect();
    word(1'b0, 24'h0, 8'ha3, 8'hb4);
    waitIdle();
    frame(8'h02, 24'h000300, 8'hcc);
    waitIdle();
    cmd(8'h04);
    flags(5'h00);
    readChk(8'h03, 24'h000100, '{8'ha1, 8'hb2, 8'ha3, 8'hb4});
    readChk(8'h03, 24'h000300, '{8'hff});
    // Top word, then no wrap; read wraps
    cmd(8'h06);
    word(1'b1, 24'h001ffe, 8'he1, 8'he2);
    waitIdle();
    word(1'b0, 24'h0, 8'he3, 8'he4);
    waitIdle();
    cmd(8'h04);
    readChk(8'h0b, 24'h001ffe, '{8'he1, 8'he2, 8'hff});
    // Pin busy mode
    cmd(8'h70);
    flags(5'b00010);
    cmd(8'h06);
    word(1'b1, 24'h000200, 8'h12, 8'h34);
    u_host.select();
    u_host.ck(2);
    chk({6'h0, soOe, soOut}, 8'h02);
    u_host.deselect();
    chk({7'h0, soOe}, 8'h00);
    waitIdle();
    u_host.select();
    u_host.ck(2);
    chk({6'h0, soOe, soOut}, 8'h03);
    u_host.sendByte(8'h05);
    u_host.readByte(d);
    chk(d, 8'hff);
    u_host.deselect();
    cmd(8'h04);
    cmd(8'h80);
    flags(5'h00);
    readChk(8'h03, 24'h000200, '{8'h12, 8'h34});
    // Erases: protected, sector, 32K block
    protOn  = 1'b1;
    protLow = 13'h0000;
    erase(8'hd8, 24'h000010);
    readChk(8'h03, 24'h000010, '{8'ha5});
    protOn = 1'b0;
    erase(8'h20, 24'h001abc);
    readChk(8'h03, 24'h0017ff, '{8'hff});
    readChk(8'h03, 24'h000010, '{8'ha5, 8'h5a});
    erase(8'h52, 24'h000123);
    readChk(8'h03, 24'h000010, '{8'hff, 8'hff});
    // Reset in mid-run clears the latch
    cmd(8'h06);
    rstN = 1'b0;
    u_host.ck(3);
    flags(5'h00);
    rstN = 1'b1;
    u_host.ck(6);
    flags(5'h00);
    conclude();
  end
endmodule
